// >>> src/tci_timer.sv
// three channel interval timer with avalon-mm register slave
`timescale 1ns/1ps
`default_nettype none
`include "tci_defines.svh"
module tci_timer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [1:0] gate_in,
    output logic [1:0] timer_out,
    output logic baud_clk,
    output logic irq
);
    import tci_pkg::*;
    // ----------------------------------------
    // state
    // ----------------------------------------
    tci_mode_e mode_r [3];
    logic [2:0] bcd_r;
    tci_acc_e acc_r [3];
    logic [2:0] wr_hi_r, rd_hi_r, latched_r;
    logic [7:0] lsb_r [3];
    tci_cnt_t latch_r [3];
    logic [2:0] load_r;
    tci_cnt_t ldval_r [3];
    logic [2:0] stat_r, ien_r, gate_r;
    logic ack_r;
    logic [31:0] rdata_r;
    tci_cnt_t cnt_w [3];
    logic [2:0] out_w, tc_w;
    logic tick;
    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire req = (avs_read || avs_write) && !ack_r;
    wire wr_go = avs_write && !ack_r;
    wire rd_go = avs_read && !ack_r;
    wire [1:0] wsel = avs_address[1:0];
    wire is_cnt = (avs_address[3:2] == 2'b00) && (wsel != 2'h3);
    wire is_ctrl = (avs_address == `TCI_OFF_CTRL);
    wire [1:0] cw_sel = avs_writedata[`TCI_CW_SEL_HI:`TCI_CW_SEL_LO];
    wire [1:0] cw_acc = avs_writedata[`TCI_CW_ACC_HI:`TCI_CW_ACC_LO];
    wire [2:0] cw_mode = avs_writedata[`TCI_CW_MODE_HI:`TCI_CW_MODE_LO];
    wire cw_ok = (cw_sel != 2'h3);
    wire cw_latch = cw_ok && (cw_acc == 2'h0);
    wire [2:0] clr_w = (wr_go && avs_address == `TCI_OFF_CLR) ? avs_writedata[2:0] : 3'h0;
    assign avs_waitrequest = req; // one wait cycle on every access
    assign avs_readdata = rdata_r;
    assign irq = |(stat_r & ien_r);
    assign timer_out = out_w[1:0];
    assign baud_clk = out_w[2];
    // ----------------------------------------
    // counters
    // ----------------------------------------
    tci_prescale u_pre (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick)
    );
    for (genvar g = 0; g < 3; g++) begin : g_ch
        // the baud channel has no gate pin; software gate only
        wire gate_w;
        if (g == 2) begin : g_sw
            assign gate_w = gate_r[g];
        end else begin : g_pin
            assign gate_w = gate_r[g] && gate_in[g];
        end
        tci_counter u_cnt (
            .clk(clk),
            .rst_n(rst_n),
            .tick(tick),
            .gate(gate_w),
            .load(load_r[g]),
            .load_val(ldval_r[g]),
            .mode(mode_r[g]),
            .bcd(bcd_r[g]),
            .count(cnt_w[g]),
            .cnt_out(out_w[g]),
            .tc_pulse(tc_w[g])
        );
        wire hit = is_cnt && (wsel == 2'(g));
        wire cw_me = wr_go && is_ctrl && cw_ok && (cw_sel == 2'(g));
        wire two_b = (acc_r[g] == TCI_ACC_BOTH);
        wire wr_cnt = wr_go && hit;
        wire rd_cnt = rd_go && hit;
        wire wr_done = wr_cnt && (!two_b || wr_hi_r[g]);
        tci_cnt_t src;
        assign src = latched_r[g] ? latch_r[g] : cnt_w[g];
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                mode_r[g] <= TCI_M_TCINT;
                bcd_r[g] <= 1'b0;
                acc_r[g] <= TCI_ACC_BOTH;
                wr_hi_r[g] <= 1'b0;
                rd_hi_r[g] <= 1'b0;
                latched_r[g] <= 1'b0;
                lsb_r[g] <= 8'h00;
                latch_r[g] <= 16'h0000;
                load_r[g] <= 1'b0;
                ldval_r[g] <= 16'h0000;
            end else begin
                load_r[g] <= wr_done;
                if (cw_me && cw_latch) begin
                    latch_r[g] <= cnt_w[g];
                    latched_r[g] <= 1'b1;
                end else if (cw_me) begin
                    mode_r[g] <= tci_mode_e'(cw_mode);
                    bcd_r[g] <= avs_writedata[`TCI_CW_BCD];
                    acc_r[g] <= tci_acc_e'(cw_acc);
                    wr_hi_r[g] <= 1'b0;
                    rd_hi_r[g] <= 1'b0;
                end else if (rd_cnt) begin
                    rd_hi_r[g] <= two_b && !rd_hi_r[g];
                    if (!two_b || rd_hi_r[g]) latched_r[g] <= 1'b0;
                end
                if (wr_cnt) begin
                    unique case (acc_r[g])
                        TCI_ACC_LSB: ldval_r[g] <= {8'h00, avs_writedata[7:0]};
                        TCI_ACC_MSB: ldval_r[g] <= {avs_writedata[7:0], 8'h00};
                        default: begin
                            if (wr_hi_r[g]) ldval_r[g] <= {avs_writedata[7:0], lsb_r[g]};
                            else lsb_r[g] <= avs_writedata[7:0];
                            wr_hi_r[g] <= !wr_hi_r[g];
                        end
                    endcase
                end
            end
        end
    end
    // ----------------------------------------
    // read mux
    // ----------------------------------------
    logic [7:0] cnt_byte;
    always_comb begin
        cnt_byte = 8'h00;
        for (int i = 0; i < 3; i++) begin
            if (wsel == 2'(i)) begin
                if (acc_r[i] == TCI_ACC_MSB || (acc_r[i] == TCI_ACC_BOTH && rd_hi_r[i])) begin
                    cnt_byte = (latched_r[i] ? latch_r[i][15:8] : cnt_w[i][15:8]);
                end else begin
                    cnt_byte = (latched_r[i] ? latch_r[i][7:0] : cnt_w[i][7:0]);
                end
            end
        end
    end
    wire [31:0] rd_mux = is_cnt ? {24'h0, cnt_byte} :
        (avs_address == `TCI_OFF_STAT) ? {29'h0, stat_r} :
        (avs_address == `TCI_OFF_IEN) ? {29'h0, ien_r} :
        (avs_address == `TCI_OFF_GATE) ? {29'h0, gate_r} : 32'h0000_0000;
    // ----------------------------------------
    // bus and interrupt registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            stat_r <= 3'h0;
            ien_r <= 3'h0;
            gate_r <= `TCI_GATE_RST;
        end else begin
            ack_r <= req;
            if (rd_go) rdata_r <= rd_mux;
            // a new terminal count wins over a clear in the same cycle
            stat_r <= (stat_r & ~clr_w) | tc_w;
            if (wr_go && avs_address == `TCI_OFF_IEN) ien_r <= avs_writedata[2:0];
            if (wr_go && avs_address == `TCI_OFF_GATE) gate_r <= avs_writedata[2:0];
        end
    end
endmodule : tci_timer
`default_nettype wire

// >>> src/tci_defines.svh
// offsets, field positions, reset values and timing counts of the interval timer
`ifndef TCI_DEFINES_SVH
`define TCI_DEFINES_SVH
// ----------------------------------------
// register word offsets (word addresses, not byte addresses)
// ----------------------------------------
`define TCI_OFF_CNT0 4'h0
`define TCI_OFF_CNT1 4'h1
`define TCI_OFF_CNT2 4'h2
`define TCI_OFF_CTRL 4'h3
`define TCI_OFF_STAT 4'h4
`define TCI_OFF_CLR 4'h5
`define TCI_OFF_IEN 4'h6
`define TCI_OFF_GATE 4'h7
// ----------------------------------------
// control word fields
// ----------------------------------------
`define TCI_CW_SEL_HI 7
`define TCI_CW_SEL_LO 6
`define TCI_CW_ACC_HI 5
`define TCI_CW_ACC_LO 4
`define TCI_CW_MODE_HI 3
`define TCI_CW_MODE_LO 1
`define TCI_CW_BCD 0
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define TCI_GATE_RST 3'h7
`define TCI_CLK_HZ 100000000
`define TCI_CNT_HZ 2000000
`define TCI_CNT_DIV (`TCI_CLK_HZ / `TCI_CNT_HZ)
`endif

// >>> src/tci_pkg.sv
// types shared by the interval timer files
package tci_pkg;
    typedef enum logic [1:0] {
        TCI_ACC_LATCH = 2'h0,
        TCI_ACC_LSB = 2'h1,
        TCI_ACC_MSB = 2'h2,
        TCI_ACC_BOTH = 2'h3
    } tci_acc_e;
    typedef enum logic [2:0] {
        TCI_M_TCINT = 3'h0,
        TCI_M_ONESHOT = 3'h1,
        TCI_M_RATE = 3'h2,
        TCI_M_SQUARE = 3'h3,
        TCI_M_SWSTB = 3'h4,
        TCI_M_HWSTB = 3'h5
    } tci_mode_e;
    typedef enum logic [1:0] {
        TCI_LD_IDLE = 2'b00,
        TCI_LD_RUN = 2'b01,
        TCI_LD_WAIT = 2'b11
    } tci_run_e;
    typedef logic [15:0] tci_cnt_t;
endpackage : tci_pkg

// >>> src/tci_prescale.sv
// divider making the one-cycle count-rate enable
`timescale 1ns/1ps
`default_nettype none
`include "tci_defines.svh"
module tci_prescale (
    input wire logic clk,
    input wire logic rst_n,
    output logic tick
);
    localparam logic [7:0] DIV_M1 = 8'(`TCI_CNT_DIV - 1);
    logic [7:0] div_r;
    assign tick = (div_r == DIV_M1);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= 8'h00;
        end else begin
            div_r <= tick ? 8'h00 : div_r + 8'h01;
        end
    end
endmodule : tci_prescale
`default_nettype wire

// >>> src/tci_counter.sv
// one 16-bit down counter with mode output logic
`timescale 1ns/1ps
`default_nettype none
`include "tci_defines.svh"
module tci_counter (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic gate,
    input wire logic load,
    input wire tci_pkg::tci_cnt_t load_val,
    input wire tci_pkg::tci_mode_e mode,
    input wire logic bcd,
    output tci_pkg::tci_cnt_t count,
    output logic cnt_out,
    output logic tc_pulse
);
    import tci_pkg::*;
    tci_cnt_t cnt_r, reload_r;
    logic out_r, run_r, sq_hi_r;
    // bcd decrement, digit by digit
    function automatic tci_cnt_t dec(input tci_cnt_t v, input logic b);
        tci_cnt_t r;
        logic bor;
        r = v;
        bor = 1'b1;
        if (!b) begin
            r = v - 16'h0001;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (bor) begin
                    if (v[i*4 +: 4] == 4'h0) begin
                        r[i*4 +: 4] = 4'h9;
                    end else begin
                        r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
                        bor = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction : dec
    wire free_run = (mode == TCI_M_RATE) || (mode == TCI_M_SQUARE) || (mode == TCI_M_TCINT);
    wire step = tick && run_r && (gate || !free_run);
    wire at_one = (cnt_r == 16'h0001);
    wire at_two = (cnt_r == 16'h0002);
    wire tc_now = step && at_one;
    tci_cnt_t nxt_dec;
    assign nxt_dec = dec(cnt_r, bcd);
    assign count = cnt_r;
    assign cnt_out = out_r;
    assign tc_pulse = tc_now && (mode == TCI_M_TCINT);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 16'h0000;
            reload_r <= 16'h0000;
            run_r <= 1'b0;
            out_r <= 1'b1;
            sq_hi_r <= 1'b1;
        end else if (load) begin
            cnt_r <= load_val;
            reload_r <= load_val;
            run_r <= 1'b1;
            out_r <= (mode != TCI_M_TCINT);
            sq_hi_r <= 1'b1;
        end else if (step) begin
            unique case (mode)
                TCI_M_TCINT: begin
                    cnt_r <= nxt_dec;
                    if (at_one) out_r <= 1'b1;
                end
                TCI_M_RATE: begin
                    cnt_r <= at_one ? reload_r : nxt_dec;
                    out_r <= !at_two;
                end
                TCI_M_SQUARE: begin
                    // count by two per half so both halves take n/2 ticks, (n+1)/2 when n is odd
                    if (cnt_r <= 16'h0002) begin
                        cnt_r <= reload_r;
                        sq_hi_r <= !sq_hi_r;
                        out_r <= !sq_hi_r;
                    end else begin
                        cnt_r <= dec(nxt_dec, bcd);
                    end
                end
                TCI_M_SWSTB, TCI_M_ONESHOT, TCI_M_HWSTB: begin
                    cnt_r <= nxt_dec;
                    out_r <= !at_one;
                    if (at_one) run_r <= 1'b0;
                end
                default: begin
                    cnt_r <= nxt_dec;
                end
            endcase
        end else if (tick && (mode == TCI_M_SWSTB)) begin
            out_r <= 1'b1;
        end
    end
endmodule : tci_counter
`default_nettype wire

// >>> test/tci_host.sv
// avalon-mm host model playing the cpu side of the timer register bus
`timescale 1ns/1ps
`default_nettype none
module tci_host (
    input wire logic clk,
    output var logic [3:0] avs_address,
    output var logic avs_read,
    output var logic avs_write,
    output var logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    initial begin
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
    end
    // ----
    // one transfer, held until waitrequest is seen low
    // ----
    // only plain bus reads and writes reach the timer
    task automatic xfer(input logic rw, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !rw;
        avs_write <= rw;
        // looked at on the rising edge itself, before that edge's updates land; no cycle count assumed
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : xfer
    // control word always goes out before the count bytes
    task automatic load(input logic [3:0] a, input logic [7:0] cw, input logic [15:0] n);
        logic [31:0] q;
        xfer(1'b1, 4'h3, {24'h0, cw}, q);
        xfer(1'b1, a, {24'h0, n[7:0]}, q);
        if (cw[5:4] == 2'h3) begin
            xfer(1'b1, a, {24'h0, n[15:8]}, q);
        end
    endtask : load
endmodule : tci_host
`default_nettype wire

// >>> test/tci_timer_props.sv
// port-level assertions of the interval timer
`timescale 1ns/1ps
`default_nettype none
module tci_timer_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [1:0] gate_in,
    input wire logic [1:0] timer_out,
    input wire logic baud_clk,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ----
    // low-time counter of counter 1, only ever run in rate mode by the bench
    // ----
    logic [7:0] low_len_r;
    logic [7:0] low_len_nxt;
    wire logic req = avs_read | avs_write;
    assign low_len_nxt = timer_out[1] ? 8'h00 : low_len_r + 8'h01;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_len_r <= 8'h00;
        end else begin
            low_len_r <= low_len_nxt;
        end
    end
    AST_WAIT_FIRST: assert property ($rose(req) |-> avs_waitrequest)
        else $error("no wait cycle on a new request");
    AST_ONE_WAIT: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("more than one wait cycle");
    AST_UNMAPPED: assert property (avs_read && !avs_waitrequest && avs_address[3] |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    AST_UPPER_ZERO: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("read data above byte not zero");
    AST_IEN_OFF: assert property (avs_write && !avs_waitrequest && avs_address == 4'h6 &&
        avs_writedata[2:0] == 3'h0 |=> !irq)
        else $error("irq stays up with all enables cleared");
    AST_RATE_LOW: assert property ($rose(timer_out[1]) |-> low_len_r == 8'h32)
        else $error("rate pulse not one count period");
    AST_RESET_OUT: assert property ($rose(rst_n) |-> timer_out == 2'h3 && baud_clk && !irq)
        else $error("outputs not idle after reset");
    AST_GATE_HOLD: assert property (!gate_in[0] [*3] |-> $stable(timer_out[0]))
        else $error("output moved with gate inactive");
    cover property ($rose(irq));
    cover property ($fell(timer_out[1]));
    cover property ($fell(baud_clk));
endmodule : tci_timer_props
bind tci_timer tci_timer_props i_props (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .gate_in(gate_in), .timer_out(timer_out), .baud_clk(baud_clk), .irq(irq));
`default_nettype wire

// >>> test/tb.sv
// self-checking bench of the three channel interval timer
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] gate_in = 2'h3;
    logic [3:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] timer_out;
    logic baud_clk;
    logic irq;
    logic [31:0] lo;
    logic [31:0] hi;
    logic [15:0] v;
    int errors = 0;
    int checks = 0;
    int n;
    wire logic [2:0] outs = {baud_clk, timer_out};
    tci_timer i_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .gate_in(gate_in), .timer_out(timer_out), .baud_clk(baud_clk), .irq(irq));
    tci_host i_host (.clk(clk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    always #5 clk = ~clk;
    // ----
    // helpers
    // ----
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        i_host.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        i_host.xfer(1'b0, a, 32'h0, q);
        chk(q & m, e);
    endtask : rd
    task automatic see_irq(input logic e);
        @(negedge clk);
        chk(irq, e);
    endtask : see_irq
    // cycles until output b next changes, bounded so a dead output cannot hang
    task automatic wait_chg(input int b, output int c);
        logic s;
        s = outs[b];
        c = 0;
        while (outs[b] === s && c < 3000) begin
            @(negedge clk);
            c++;
        end
    endtask : wait_chg
    // full period after one resync edge; h is the second half when non-zero
    task automatic per(input int b, input int e, input int h);
        int a;
        int c;
        // let the edge that ended the last transfer settle before sampling
        @(negedge clk);
        wait_chg(b, a);
        wait_chg(b, a);
        wait_chg(b, c);
        chk(a + c, e);
        if (h != 0) chk(c, h);
    endtask : per
    task automatic print_verdict();
        if (errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #300000;
        errors++;
        print_verdict();
    end
    // ----
    // test sequence
    // ----
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(4'h4, 32'h1, 32'h0);
        rd(4'h7, 32'h7, 32'h7);
        rd(4'h9, 32'hFFFFFFFF, 32'h0);
        wr(4'hA, 32'hFF);
        rd(4'hA, 32'hFFFFFFFF, 32'h0);
        i_host.load(4'h1, 8'h74, 16'h0004);
        per(1, 200, 0);
        wr(4'h6, 32'h1);
        i_host.load(4'h0, 8'h10, 16'h0003);
        see_irq(1'b0);
        n = 0;
        while (irq !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        chk(irq === 1'b1 && n > 90, 1'b1);
        rd(4'h4, 32'h1, 32'h1);
        wr(4'h6, 32'h0);
        see_irq(1'b0);
        wr(4'h6, 32'h1);
        see_irq(1'b1);
        wr(4'h5, 32'h1);
        rd(4'h4, 32'h1, 32'h0);
        see_irq(1'b0);
        // binary then bcd: the same load is sixteen or ten counts
        for (int i = 0; i < 2; i++) begin
            i_host.load(4'h0, 8'h34 | 8'(i), 16'h0010);
            per(0, (i != 0) ? 500 : 800, 0);
        end
        i_host.load(4'h0, 8'h34, 16'h1000);
        repeat (500) @(posedge clk);
        wr(4'h3, 32'h0);
        repeat (200) @(posedge clk);
        i_host.xfer(1'b0, 4'h0, 32'h0, lo);
        i_host.xfer(1'b0, 4'h0, 32'h0, hi);
        v = {hi[7:0], lo[7:0]};
        chk(v >= 16'h0FF4 && v <= 16'h0FF8, 1'b1);
        i_host.load(4'h0, 8'h36, 16'h0004);
        per(0, 200, 100);
        @(posedge clk);
        gate_in <= 2'h2;
        repeat (300) @(posedge clk);
        gate_in <= 2'h3;
        per(0, 200, 100);
        // high byte only, one-shot mode: 03 lands as 0x0300
        i_host.load(4'h0, 8'h22, 16'h0003);
        i_host.xfer(1'b0, 4'h0, 32'h0, lo);
        chk(lo[7:0] == 8'h03 || lo[7:0] == 8'h02, 1'b1);
        i_host.load(4'h0, 8'h38, 16'h0005);
        @(negedge clk);
        wait_chg(0, n);
        chk(n >= 200 && n <= 310, 1'b1);
        wait_chg(0, n);
        chk(n, 50);
        i_host.load(4'h2, 8'hB6, 16'h0002);
        per(2, 100, 50);
        // select code 3 must leave every counter alone
        wr(4'h3, 32'hF6);
        per(1, 200, 0);
        print_verdict();
    end
endmodule : tb
`default_nettype wire
